// file: src/agk_gate_reset.v
// agk_gate_reset.v: hardware a20 gate and keyboard reset acceleration with fast port
// assumes a 10 MHz clk_sys, avalon-mm master, and a controller command/data byte strobe
`include "agk_map.vh"
`timescale 1ns/100ps
`default_nettype none

module agk_gate_reset (
    input wire clk_sys,
    input wire rstn,
    // avalon-mm slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg [1:0] avs_response,
    // host byte stream seen by the keyboard controller
    input wire host_byte_valid,
    input wire host_byte_is_cmd,
    input wire [7:0] host_byte,
    // firmware-driven outputs of the controller
    input wire fw_addr_gate,
    input wire fw_kbd_reset_n,
    // chipset side
    output reg address_line_gate,
    output reg keyboard_reset_out_n,
    output reg [1:0] ctrl_clock_sel
);

    // bus timing: a request seen with waitrequest high gets waitrequest low
    // for exactly the next cycle; that edge is where a write lands and where
    // read data and response stand, so a master that holds its request until
    // waitrequest is low never picks up a stale word
    // unmapped addresses answer with slave error and read zero; writes there
    // are dropped, so a stray pointer cannot move the gate or the reset
    // both registers live in byte lane 0; upper write bits are ignored
    //
    // host stream: host_byte_valid is one cycle per byte; a command byte arms
    // or disarms the data decode, and only the first data byte after the
    // write-output command moves the hardware gate and reset levels
    // any other command, the pulse command included, disarms the decode
    // bytes may come back to back; nothing here needs idle cycles between them
    //
    // pulse: the pulse command with the hardware reset path on, or a 0 to 1
    // write of the fast reset bit with the fast port on, starts the sequencer
    // a request that arrives while a pulse runs is dropped, not queued, so
    // software must let one pulse finish before it asks for the next
    // the fast reset bit must be written 0 again before it can pulse again
    //
    // outputs: every output is a flop, so each path shows its result one
    // cycle after the register that feeds it; the pulse always wins over the
    // selected reset level, and the fast gate bit is or-ed onto the gate
    // the firmware levels are only looked at while the hardware select of
    // the same output is off, so the two sources never fight
    //
    // limitation: the controller clock rate is only reported on
    // ctrl_clock_sel; all timing here runs on clk_sys and is scaled to the
    // chosen rate, which costs up to one system cycle of extra pulse length
    // trade-off: counts are fixed at build time rather than programmable,
    // which keeps the sequencer small at the price of flexibility
    //
    // reset: the gate comes up low, keyboard reset comes up released, and the
    // bus holds waitrequest high until the first request is seen

    // least delay and width in controller ticks, rounded up so that no rate
    // ever shortens a pulse below its minimum
    localparam [31:0] DLY_6 = (`AGK_DELAY_NS * 1000 + `AGK_PER_PS_6M - 1) / `AGK_PER_PS_6M;
    localparam [31:0] DLY_8 = (`AGK_DELAY_NS * 1000 + `AGK_PER_PS_8M - 1) / `AGK_PER_PS_8M;
    localparam [31:0] DLY_12 = (`AGK_DELAY_NS * 1000 + `AGK_PER_PS_12M - 1) / `AGK_PER_PS_12M;
    localparam [31:0] DLY_16 = (`AGK_DELAY_NS * 1000 + `AGK_PER_PS_16M - 1) / `AGK_PER_PS_16M;
    localparam [31:0] WID_6 = (`AGK_WIDTH_NS * 1000 + `AGK_PER_PS_6M - 1) / `AGK_PER_PS_6M;
    localparam [31:0] WID_8 = (`AGK_WIDTH_NS * 1000 + `AGK_PER_PS_8M - 1) / `AGK_PER_PS_8M;
    localparam [31:0] WID_12 = (`AGK_WIDTH_NS * 1000 + `AGK_PER_PS_12M - 1) / `AGK_PER_PS_12M;
    localparam [31:0] WID_16 = (`AGK_WIDTH_NS * 1000 + `AGK_PER_PS_16M - 1) / `AGK_PER_PS_16M;
    // this block only sees clk_sys, so each controller tick is converted to
    // system cycles; rounding up keeps every least time at every rate
    localparam [31:0] SYS_PS = `AGK_SYS_NS * 1000;
    // full-width cycle counts; the extra cycle covers the truncating divide
    localparam [31:0] DLY_SYS_6_W = DLY_6 * `AGK_PER_PS_6M / SYS_PS + 1;
    localparam [31:0] DLY_SYS_8_W = DLY_8 * `AGK_PER_PS_8M / SYS_PS + 1;
    localparam [31:0] DLY_SYS_12_W = DLY_12 * `AGK_PER_PS_12M / SYS_PS + 1;
    localparam [31:0] DLY_SYS_16_W = DLY_16 * `AGK_PER_PS_16M / SYS_PS + 1;
    localparam [31:0] WID_SYS_6_W = WID_6 * `AGK_PER_PS_6M / SYS_PS + 1;
    localparam [31:0] WID_SYS_8_W = WID_8 * `AGK_PER_PS_8M / SYS_PS + 1;
    localparam [31:0] WID_SYS_12_W = WID_12 * `AGK_PER_PS_12M / SYS_PS + 1;
    localparam [31:0] WID_SYS_16_W = WID_16 * `AGK_PER_PS_16M / SYS_PS + 1;
    // every count is far below 2^16, so the sequencer counter keeps 16 bits
    localparam [15:0] DLY_SYS_6 = DLY_SYS_6_W[15:0];
    localparam [15:0] DLY_SYS_8 = DLY_SYS_8_W[15:0];
    localparam [15:0] DLY_SYS_12 = DLY_SYS_12_W[15:0];
    localparam [15:0] DLY_SYS_16 = DLY_SYS_16_W[15:0];
    localparam [15:0] WID_SYS_6 = WID_SYS_6_W[15:0];
    localparam [15:0] WID_SYS_8 = WID_SYS_8_W[15:0];
    localparam [15:0] WID_SYS_12 = WID_SYS_12_W[15:0];
    localparam [15:0] WID_SYS_16 = WID_SYS_16_W[15:0];

    // fixed levels of the reserved fast port bits
    localparam [7:0] FAST_FIXED = `AGK_FAST_FIXED;

    // pulse sequencer states, one-hot
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_DELAY = 3'h2;
    localparam [2:0] ST_LOW = 3'h4;

    reg [7:0] cfg_r;
    reg [1:0] fast_r;
    reg expect_data_r;
    reg hw_gate_r;
    reg hw_rst_level_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [15:0] cnt_r;
    reg [15:0] cnt_nxt;
    reg pulse_low_r;
    reg [15:0] dly_cycles;
    reg [15:0] wid_cycles;
    reg gate_nxt;
    reg rst_n_nxt;
    reg [31:0] rd_word_nxt;
    reg [1:0] rsp_nxt;
    wire [7:0] fast_rd_byte;

    // address decode and the edge at which a write lands
    wire hit_cfg = (avs_address == `AGK_OFS_CTL_CFG);
    wire hit_fast = (avs_address == `AGK_OFS_FAST_PORT);
    wire wr_take = avs_write && !avs_waitrequest;

    // configuration fields
    wire fast_en = cfg_r[`AGK_CFG_FAST_EN];
    wire hw_a20 = cfg_r[`AGK_CFG_HW_A20];
    wire hw_rst = cfg_r[`AGK_CFG_HW_RST];

    // pulse requests from either path
    wire cmd_pulse = host_byte_valid && host_byte_is_cmd && (host_byte == `AGK_CMD_PULSE);
    // only a 0 to 1 change of the fast reset bit requests a pulse
    wire fast_rst_rise = wr_take && hit_fast && fast_en && avs_writedata[`AGK_FAST_RST]
        && !fast_r[`AGK_FAST_RST];
    wire pulse_req = (cmd_pulse && hw_rst) || fast_rst_rise;

    // fast port readback, bit by bit: reserved bits show their fixed level,
    // the two live bits show what software last wrote
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_fast_rd
            if (gi == `AGK_FAST_A20 || gi == `AGK_FAST_RST) begin : g_live
                assign fast_rd_byte[gi] = fast_r[gi];
            end else begin : g_fixed
                assign fast_rd_byte[gi] = FAST_FIXED[gi];
            end
        end
    endgenerate

    // read word and response chosen per address; unmapped places read zero
    always @* begin
        rd_word_nxt = 32'h0000_0000;
        rsp_nxt = 2'h2; // slaveerror unless an address hits
        if (hit_cfg) begin
            rd_word_nxt = {24'h000000, cfg_r};
            rsp_nxt = 2'h0;
        end else if (hit_fast) begin
            rd_word_nxt = {24'h000000, fast_rd_byte};
            rsp_nxt = 2'h0;
        end
    end

    // waitrequest drops for exactly one cycle per request; holding it high
    // otherwise means no request is answered before the slave has seen its
    // address, at the cost of one wait cycle on every access
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // read data and response load with the answer and then stand until the
    // next answer, so the master can take them at the waitrequest-low edge
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_readdata <= rd_word_nxt;
            avs_response <= rsp_nxt;
        end
    end

    // register writes; reserved config bits stay zero
    // the fast bits are stored even while the port is off, so that turning
    // the port on later applies the gate bit software last wrote
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= `AGK_CFG_RESET;
            fast_r <= 2'h0;
        end else if (wr_take) begin
            if (hit_cfg) begin
                cfg_r <= avs_writedata[7:0] & `AGK_CFG_WMASK;
            end
            if (hit_fast) begin
                fast_r <= avs_writedata[1:0];
            end
        end
    end

    // hardware decode of the write-output command and its data byte
    // only the first data byte after the command counts; a stray data byte
    // must not move the gate, or a keyboard byte could drop the address line
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            expect_data_r <= 1'b0;
            hw_gate_r <= 1'b0;
            hw_rst_level_r <= 1'b1;
        end else if (host_byte_valid) begin
            if (host_byte_is_cmd) begin
                expect_data_r <= (host_byte == `AGK_CMD_WR_OUT);
            end else begin
                expect_data_r <= 1'b0;
                if (expect_data_r) begin
                    hw_gate_r <= host_byte[1];
                    hw_rst_level_r <= host_byte[0];
                end
            end
        end
    end

    // counts per selected clock rate
    // all four rates land on the same system cycle counts today, but the
    // table stays per rate so a different system clock keeps every minimum
    always @* begin
        case (cfg_r[`AGK_CFG_CLKSEL_HI:`AGK_CFG_CLKSEL_LO])
            2'h0: begin
                dly_cycles = DLY_SYS_6;
                wid_cycles = WID_SYS_6;
            end
            2'h1: begin
                dly_cycles = DLY_SYS_8;
                wid_cycles = WID_SYS_8;
            end
            2'h2: begin
                dly_cycles = DLY_SYS_12;
                wid_cycles = WID_SYS_12;
            end
            default: begin
                dly_cycles = DLY_SYS_16;
                wid_cycles = WID_SYS_16;
            end
        endcase
    end

    // pulse sequencer: wait the delay, then hold reset low for the width;
    // a request during a running pulse is ignored, not queued
    // counting down to one makes the delay state last exactly its count
    // and the low state exactly its count
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (pulse_req) begin
                    state_nxt = ST_DELAY;
                    cnt_nxt = dly_cycles;
                end
            end
            ST_DELAY: begin
                if (cnt_r == 16'h0001) begin
                    state_nxt = ST_LOW;
                    cnt_nxt = wid_cycles;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            ST_LOW: begin
                if (cnt_r == 16'h0001) begin
                    state_nxt = ST_IDLE;
                    cnt_nxt = 16'h0000;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt = 16'h0000;
            end
        endcase
    end

    // sequencer state and count; the low flag is registered from the next
    // state so it lines up with the low state itself
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            cnt_r <= 16'h0000;
            pulse_low_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pulse_low_r <= (state_nxt == ST_LOW);
        end
    end

    // output selection: firmware or hardware path, then merged with fast port
    // the pulse overrides any level so a reset request is never masked
    always @* begin
        gate_nxt = hw_a20 ? hw_gate_r : fw_addr_gate;
        rst_n_nxt = hw_rst ? hw_rst_level_r : fw_kbd_reset_n;
        if (fast_en) begin
            gate_nxt = gate_nxt | fast_r[`AGK_FAST_A20];
        end
        if (pulse_low_r) begin
            rst_n_nxt = 1'b0;
        end
    end

    // outputs from flops; costs one cycle of latency on each path
    // in return the chipset never sees a glitch while the sources switch
    // or while a configuration write changes the selection
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            address_line_gate <= 1'b0;
            keyboard_reset_out_n <= 1'b1;
            ctrl_clock_sel <= 2'h2;
        end else begin
            address_line_gate <= gate_nxt;
            keyboard_reset_out_n <= rst_n_nxt;
            ctrl_clock_sel <= cfg_r[`AGK_CFG_CLKSEL_HI:`AGK_CFG_CLKSEL_LO];
        end
    end

endmodule

`default_nettype wire

// file: src/agk_map.vh
// agk_map.vh: register offsets, field positions, reset values and timing for the a20 gate block
// assumes avalon-mm word addressing in bytes; included by its bare name
`ifndef AGK_MAP_VH
`define AGK_MAP_VH

// byte addresses of the two registers on the avalon bus
`define AGK_OFS_CTL_CFG 8'hf0
`define AGK_OFS_FAST_PORT 8'hf4

// keyboard control config fields
`define AGK_CFG_RESET 8'h80
`define AGK_CFG_CLKSEL_HI 7
`define AGK_CFG_CLKSEL_LO 6
`define AGK_CFG_FAST_EN 2
`define AGK_CFG_HW_A20 1
`define AGK_CFG_HW_RST 0
`define AGK_CFG_WMASK 8'hc7

// fast port fields and fixed reserved bits
`define AGK_FAST_RESET 8'h24
`define AGK_FAST_A20 1
`define AGK_FAST_RST 0
`define AGK_FAST_FIXED 8'h24

// keyboard controller commands
`define AGK_CMD_WR_OUT 8'hd1
`define AGK_CMD_PULSE 8'hfe

// pulse timing in ns, counted on the selected controller clock
`define AGK_DELAY_NS 14000
`define AGK_WIDTH_NS 6000
// controller clock periods in ps for codes 00..11 (6, 8, 12, 16 MHz)
`define AGK_PER_PS_6M 166667
`define AGK_PER_PS_8M 125000
`define AGK_PER_PS_12M 83334
`define AGK_PER_PS_16M 62500
// system clock period in ns (10 MHz)
`define AGK_SYS_NS 100

`endif

// file: sim/agk_gate_reset_asserts.sv
// agk_gate_reset_asserts.sv: checker bound to agk_gate_reset
// assumes one 10 MHz clock and the offsets and commands of agk_map.vh
`include "agk_map.vh"
`timescale 1ns/100ps
`default_nettype none
module agk_chk (
    input wire clk_sys, input wire rstn, input wire [7:0] avs_address,
    input wire avs_read, input wire avs_write, input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata, input wire avs_waitrequest, input wire [1:0] avs_response,
    input wire host_byte_valid, input wire host_byte_is_cmd, input wire [7:0] host_byte,
    input wire fw_addr_gate, input wire fw_kbd_reset_n, input wire address_line_gate,
    input wire keyboard_reset_out_n, input wire [1:0] ctrl_clock_sel
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    reg [7:0] cfg_r;
    reg fb_r, pend_r;
    reg [9:0] cyc_r, lo_r;
    wire wr_ok = avs_write && !avs_waitrequest;
    wire fwr = wr_ok && avs_address == `AGK_OFS_FAST_PORT;
    wire d1 = host_byte_valid && host_byte_is_cmd && host_byte == `AGK_CMD_WR_OUT;
    wire dat = host_byte_valid && !host_byte_is_cmd;
    wire go = (host_byte_valid && host_byte_is_cmd && host_byte == `AGK_CMD_PULSE && cfg_r[0])
        || (fwr && avs_writedata[0] && !fb_r && cfg_r[2]);
    // mirror of config and pulse progress; a pulse ends when reset is released again
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= `AGK_CFG_RESET;
            fb_r <= 1'b0;
            pend_r <= 1'b0;
            cyc_r <= 10'h0;
            lo_r <= 10'h0;
        end else begin
            if (wr_ok && avs_address == `AGK_OFS_CTL_CFG)
                cfg_r <= avs_writedata[7:0];
            if (fwr)
                fb_r <= avs_writedata[0];
            if (go)
                pend_r <= 1'b1;
            else if (keyboard_reset_out_n && lo_r != 10'h0)
                pend_r <= 1'b0;
            cyc_r <= pend_r ? cyc_r + 10'h1 : 10'h0;
            lo_r <= keyboard_reset_out_n ? 10'h0 : lo_r + 10'h1;
        end
    end
    a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer next cycle");
    a_unmapped_err: assert property (avs_read && !avs_waitrequest && avs_address != 8'hf0
        && avs_address != 8'hf4 |-> avs_response == 2'b10 && avs_readdata == 32'h0)
        else $error("unmapped read not refused");
    a_clock_sel: assert property (wr_ok && avs_address == `AGK_OFS_CTL_CFG |->
        ##[1:2] ctrl_clock_sel == $past(avs_writedata[7:6], 2)) else $error("clock select");
    a_gate_data: assert property (d1 ##2 dat && cfg_r[1] && !cfg_r[2] |->
        ##2 address_line_gate == $past(host_byte[1], 2)) else $error("gate data");
    a_reset_data: assert property (d1 ##2 dat && cfg_r[0] && !pend_r |->
        ##2 keyboard_reset_out_n == $past(host_byte[0], 2)) else $error("reset data");
    a_pulse_delay: assert property (pend_r && $fell(keyboard_reset_out_n) |-> cyc_r >= 10'd140)
        else $error("reset pulse too early");
    a_pulse_width: assert property (pend_r && $rose(keyboard_reset_out_n) |-> lo_r >= 10'd60)
        else $error("reset pulse too short");
endmodule
bind agk_gate_reset agk_chk agk_chk_inst (.*);
`default_nettype wire

// file: sim/agk_host_model.sv
// agk_host_model.sv: host that sends controller command and data bytes
// assumes calls from one bench thread; idle byte lines show the inverse of the last byte
`timescale 1ns/100ps
`default_nettype none
module agk_host (
    input wire logic clk_sys,
    output var logic valid = 1'b0,
    output var logic is_cmd = 1'b0,
    output var logic [7:0] data = 8'h00
);
    // one byte per call as a one-edge strobe; stale lines are inverted, never left as sent
    task automatic send(input logic c, input logic [7:0] b);
        @(posedge clk_sys);
        {valid, is_cmd, data} <= {1'b1, c, b};
        @(posedge clk_sys);
        {valid, is_cmd, data} <= {1'b0, ~c, ~b};
    endtask
endmodule
`default_nettype wire

// file: sim/agk_gate_reset_tb_top.sv
// agk_gate_reset_tb_top.sv: self-checking bench for agk_gate_reset
// assumes agk_host and the bound checker are compiled before it
`include "agk_map.vh"
`timescale 1ns/100ps
`default_nettype none
module agk_gate_reset_tb_top;
    logic clk_sys = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic fw_addr_gate = 1'b0, fw_kbd_reset_n = 1'b1;
    logic [7:0] avs_address = 8'h00, q, r;
    logic [31:0] avs_writedata = 32'h0, seed = 32'h7;
    logic [1:0] rs;
    wire [31:0] avs_readdata;
    wire [7:0] host_byte;
    wire [1:0] avs_response, ctrl_clock_sel;
    wire avs_waitrequest, host_byte_valid, host_byte_is_cmd, address_line_gate, keyboard_reset_out_n;
    integer fail_count = 0, compares = 0, n, d, m_cfg = 8'h80, m_fast = 8'h24, m_hw = 1;
    always #50 clk_sys = ~clk_sys;
    agk_gate_reset agk_gate_reset_inst (.*);
    agk_host agk_host_inst (.clk_sys(clk_sys), .valid(host_byte_valid),
        .is_cmd(host_byte_is_cmd), .data(host_byte));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // the request stands until waitrequest is seen low at a rising edge; the model follows
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        {avs_write, avs_read, avs_address, avs_writedata} <= {wr, !wr, a, 24'h0, v};
        @(posedge clk_sys);
        for (n = 0; avs_waitrequest !== 1'b0 && n < 30; n++) @(posedge clk_sys);
        if (n == 30) begin
            chk(0, 1);
            complete_run();
        end
        q = avs_readdata[7:0];
        rs = avs_response;
        {avs_write, avs_read} <= 2'b00;
        if (wr && a == `AGK_OFS_CTL_CFG) m_cfg = v & `AGK_CFG_WMASK;
        if (wr && a == `AGK_OFS_FAST_PORT) m_fast = `AGK_FAST_FIXED | v[1:0];
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        bus(1'b0, a, 8'h00);
        chk(q, e);
        chk(rs, er);
    endtask
    // outputs against the model: selected source, fast port merged in by or
    task automatic outs();
        repeat (3) @(negedge clk_sys);
        chk(address_line_gate, (m_cfg[1] ? m_hw[1] : fw_addr_gate) | (m_cfg[2] & m_fast[1]));
        chk(keyboard_reset_out_n, m_cfg[0] ? m_hw[0] : fw_kbd_reset_n);
    endtask
    // 14 us of delay and 6 us low are 140 and 60 cycles; two cycles of slack for the start
    task automatic pulse();
        for (d = 0; keyboard_reset_out_n === 1'b1 && d < 400; d++) @(negedge clk_sys);
        chk(d >= 138 && d < 400, 1'b1);
        if (d == 400) complete_run();
        for (d = 0; keyboard_reset_out_n === 1'b0 && d < 400; d++) @(negedge clk_sys);
        chk(d >= 60 && d < 400, 1'b1);
        if (d == 400) complete_run();
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(`AGK_OFS_CTL_CFG, `AGK_CFG_RESET, 2'b00);
        rd(`AGK_OFS_FAST_PORT, `AGK_FAST_RESET, 2'b00);
        chk(ctrl_clock_sel, 2'b10);
        // unmapped place: the write is dropped and the read answers zero with an error
        bus(1'b1, 8'h10, 8'hff);
        rd(8'h10, 8'h00, 2'b10);
        // every clock code, with random enables and firmware levels
        for (d = 0; d < 4; d++) begin
            r = rnd();
            @(posedge clk_sys);
            fw_addr_gate <= r[6];
            fw_kbd_reset_n <= r[7];
            bus(1'b1, `AGK_OFS_CTL_CFG, {d[1:0], r[5:0]});
            rd(`AGK_OFS_CTL_CFG, m_cfg, 2'b00);
            chk(ctrl_clock_sel, d[1:0]);
            outs();
        end
        // data after the write-output command, then a stray data byte that changes nothing
        bus(1'b1, `AGK_OFS_CTL_CFG, 8'h83);
        repeat (4) begin
            r = rnd();
            agk_host_inst.send(1'b1, `AGK_CMD_WR_OUT);
            agk_host_inst.send(1'b0, r);
            m_hw = r[1:0];
            outs();
            agk_host_inst.send(1'b0, ~r);
            outs();
        end
        agk_host_inst.send(1'b1, `AGK_CMD_WR_OUT);
        agk_host_inst.send(1'b0, 8'h01);
        m_hw = 1;
        fw_addr_gate <= 1'b0;
        fw_kbd_reset_n <= 1'b1;
        // fast port ignored while disabled, merged with the gate once enabled
        bus(1'b1, `AGK_OFS_CTL_CFG, 8'h80);
        bus(1'b1, `AGK_OFS_FAST_PORT, 8'h02);
        rd(`AGK_OFS_FAST_PORT, 8'h26, 2'b00);
        outs();
        bus(1'b1, `AGK_OFS_CTL_CFG, 8'h84);
        outs();
        bus(1'b1, `AGK_OFS_FAST_PORT, 8'h00);
        outs();
        // with both paths off neither the pulse command nor the fast bit pulses
        bus(1'b1, `AGK_OFS_CTL_CFG, 8'h80);
        agk_host_inst.send(1'b1, `AGK_CMD_PULSE);
        bus(1'b1, `AGK_OFS_FAST_PORT, 8'h01);
        for (d = 0; keyboard_reset_out_n === 1'b1 && d < 220; d++) @(negedge clk_sys);
        chk(d, 220);
        bus(1'b1, `AGK_OFS_FAST_PORT, 8'h00);
        // delayed reset pulse from the command, then twice from the fast port
        bus(1'b1, `AGK_OFS_CTL_CFG, 8'h81);
        agk_host_inst.send(1'b1, `AGK_CMD_PULSE);
        pulse();
        bus(1'b1, `AGK_OFS_CTL_CFG, 8'h84);
        bus(1'b1, `AGK_OFS_FAST_PORT, 8'h01);
        pulse();
        bus(1'b1, `AGK_OFS_FAST_PORT, 8'h00);
        bus(1'b1, `AGK_OFS_FAST_PORT, 8'h01);
        pulse();
        complete_run();
    end
endmodule
`default_nettype wire
